// ---- common/opaddr_pkg.sv ----
// Purpose: shared constants and types for the operand address decoder
// Assumes: byte-wide core memory read port, one clock
// Notes:   mode numbers and control codes follow the instruction set
package opaddr_pkg;
    localparam int          ADDR_W        = 15;
    localparam int          WORD_W        = 16;
    localparam logic [2:0]  MODE_PAGE0    = 3'h0;
    localparam logic [2:0]  MODE_REL      = 3'h1;
    localparam logic [2:0]  MODE_IND_P0   = 3'h2;
    localparam logic [2:0]  MODE_IND_REL  = 3'h3;
    localparam logic [2:0]  MODE_INDEX    = 3'h4;
    localparam logic [2:0]  MODE_BIAS     = 3'h5;
    localparam logic [2:0]  MODE_EXT      = 3'h6;
    localparam logic [2:0]  MODE_LIT      = 3'h7;
    localparam logic [4:0]  OPF_JUMP      = 5'h0c;
    localparam logic [4:0]  OPF_RJUMP     = 5'h0d;
    localparam logic [2:0]  OPF_MEMREF_HI = 3'h3;
    localparam logic [2:0]  OPF_VAR_LO    = 3'h5;
    localparam logic [7:0]  CODE_IDLE     = 8'h34;
    localparam logic [3:0]  CJ_HI         = 4'h1;
    localparam logic [1:0]  WLEN_RESET    = 2'h1;
    localparam logic        OVF_RESET     = 1'b0;
    localparam int          IDX_BIT       = 15;
    localparam int          VAR_BIT       = 3;
    localparam int          FLAG_BIT      = 2;

    typedef struct packed {
        logic halt_op;
        logic trap_op;
        logic sense_switch_entry_op;
        logic page_protect_op;
        logic irq_disable_op;
        logic irq_enable_op;
        logic timer_disable_op;
        logic timer_enable_op;
        logic idle_op;
    } ctrl_t;

    typedef struct packed {
        logic [WORD_W-1:0] acc_a;
        logic [WORD_W-1:0] acc_b;
        logic [WORD_W-1:0] index_x;
    } regs_t;
endpackage

// ---- rtl/index_adder.sv ----
// Purpose: resolve a 16-bit address word with its index flag
// Assumes: address space of 15 bits
// Notes:   sums wrap within the address space
`timescale 1ns/1ps
`default_nettype none
module index_adder (
    input  wire logic [15:0] word_in,
    input  wire logic [15:0] index_in,
    output logic      [14:0] addr_out
);
    import opaddr_pkg::*;
    wire logic [14:0] sum;
    // bit 15 selects indexing; truncation keeps the wrap
    assign sum      = word_in[14:0] + index_in[14:0];
    assign addr_out = word_in[IDX_BIT] ? sum : word_in[14:0];
endmodule
`default_nettype wire

// ---- rtl/operand_address_decoder.sv ----
// Purpose: decode first byte and resolve the operand address
// Assumes: memory answers a byte read one cycle after mem_rd_out
// Notes:   execution units outside consume oper_addr_out on done_out
`timescale 1ns/1ps
`default_nettype none
module operand_address_decoder (
    input  wire logic               clock_in,
    input  wire logic               arst_n_in,
    input  wire logic               start_in,
    input  wire logic [14:0]        pc_in,
    input  wire opaddr_pkg::regs_t  regs_in,
    input  wire logic               ovf_set_in,
    input  wire logic [7:0]         mem_data_in,
    output logic                    mem_rd_out,
    output logic      [14:0]        mem_addr_out,
    output logic      [14:0]        oper_addr_out,
    output logic      [14:0]        pc_out,
    output logic                    done_out,
    output logic                    busy_out,
    output logic      [4:0]         op_field_out,
    output logic      [2:0]         mode_out,
    output logic                    memref_out,
    output logic                    var_len_out,
    output logic      [2:0]         oper_bytes_out,
    output logic      [1:0]         word_len_out,
    output logic                    overflow_out,
    output logic                    branch_taken_out,
    output opaddr_pkg::ctrl_t       ctrl_out
);
    import opaddr_pkg::*;

    typedef enum logic [6:0] {
        S_IDLE = 7'h01, S_OPC = 7'h02, S_B2 = 7'h04, S_B3 = 7'h08,
        S_IW_HI = 7'h10, S_IW_LO = 7'h20, S_DONE = 7'h40
    } state_t;

    state_t      state;
    state_t      next_state;
    logic [7:0]  opcode;
    logic [7:0]  byte2;
    logic [7:0]  byte_hi;
    logic [14:0] pc;
    logic [14:0] oar;
    logic [1:0]  wlen;
    logic        ovf;
    logic        taken;
    logic        ind_pass;
    ctrl_t       ctrl;

    ////////////////////////////////////////////////////////////////////
    // field decode of the first byte
    wire logic [4:0]  opf      = mem_data_in[7:3];
    wire logic [2:0]  mode     = mem_data_in[2:0];
    wire logic [4:0]  op_r     = opcode[7:3];
    wire logic [2:0]  mode_r   = opcode[2:0];
    wire logic        memref   = opcode[7:5] >= OPF_MEMREF_HI;
    wire logic        is_jump  = (op_r == OPF_JUMP) || (op_r == OPF_RJUMP);
    wire logic        cjump    = opcode[7:4] == CJ_HI;
    // the first byte is on the bus only in S_B2, so decode it there
    wire logic        memref_b2 = mem_data_in[7:5] >= OPF_MEMREF_HI;
    wire logic        cjump_b2  = mem_data_in[7:4] == CJ_HI;
    wire logic        jump_b2   = (opf == OPF_JUMP) || (opf == OPF_RJUMP);
    // bit 3 asks for variable length only on the paired opcodes;
    // on fixed-only ones such as multiply it names the instruction
    wire logic        var_len  = (opcode[7:5] >= OPF_VAR_LO) &&
                                 opcode[VAR_BIT];
    wire logic [2:0]  nbytes   = var_len ? {1'b0, wlen} + 3'h1
                                         : 3'h2;
    // byte y is taken straight off the bus in S_B3, where it arrives
    wire logic [14:0] sext_y   = {{7{mem_data_in[7]}}, mem_data_in};
    wire logic [14:0] zext_y   = {7'h00, mem_data_in};
    wire logic [14:0] rel_sum  = pc + sext_y;
    wire logic [14:0] bias_sum = regs_in.index_x[14:0] + zext_y;
    wire logic [15:0] ext_word = {byte2, mem_data_in};
    wire logic [15:0] ind_word = {byte_hi, mem_data_in};
    wire logic [14:0] ext_addr;
    wire logic [14:0] ind_addr;

    index_adder u_ext (
        .word_in  (ext_word),
        .index_in (regs_in.index_x),
        .addr_out (ext_addr)
    );
    index_adder u_ind (
        .word_in  (ind_word),
        .index_in (regs_in.index_x),
        .addr_out (ind_addr)
    );

    ////////////////////////////////////////////////////////////////////
    // conditional jump test, low three bits pick the condition
    logic cond;
    always_comb begin
        case (opcode[2:0])
            3'h0:    cond = ovf;
            3'h1:    cond = regs_in.acc_a == 16'h0000;
            3'h2:    cond = regs_in.acc_b == 16'h0000;
            3'h3:    cond = regs_in.index_x == 16'h0000;
            3'h4:    cond = regs_in.acc_a[15];
            3'h5:    cond = regs_in.index_x[15];
            3'h6:    cond = regs_in.acc_a == regs_in.acc_b;
            default: cond = regs_in.acc_a == regs_in.index_x;
        endcase
    end
    wire logic take = cond ^ opcode[VAR_BIT];

    ////////////////////////////////////////////////////////////////////
    // sequencing: one byte is read per state that needs memory
    always_comb begin
        next_state = state;
        case (state)
            S_IDLE:  if (start_in) next_state = S_OPC;
            S_OPC:   next_state = S_B2;
            S_B2: begin
                if (!memref_b2 && !cjump_b2)
                    next_state = S_DONE; // one-byte control
                else if (cjump_b2)
                    next_state = S_B3;
                else if (mode == MODE_INDEX ||
                         (mode == MODE_LIT && !jump_b2))
                    next_state = S_DONE;
                else
                    next_state = S_B3;
            end
            S_B3: begin
                if (cjump) next_state = S_DONE;
                else if (mode_r == MODE_IND_P0 || mode_r == MODE_IND_REL)
                    next_state = S_IW_HI;
                else if (mode_r == MODE_EXT) next_state = S_IW_HI;
                else if (mode_r == MODE_LIT) next_state = S_IW_HI;
                else next_state = S_DONE;
            end
            // a mode 7 jump spends one extra step on the first-level word
            S_IW_HI: next_state = ind_pass ? S_IW_HI : S_IW_LO;
            S_IW_LO: next_state = S_DONE;
            S_DONE:  next_state = S_IDLE;
            default: next_state = S_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // memory address driven combinationally from the current step
    always_comb begin
        mem_rd_out   = 1'b0;
        mem_addr_out = pc;
        case (state)
            S_OPC:   mem_rd_out = 1'b1;
            // mode 4 and non-jump mode 7 read no second byte, so the counter stays put
            S_B2:    mem_rd_out = next_state == S_B3;
            S_B3: begin
                mem_rd_out = !cjump && mode_r != MODE_PAGE0 &&
                             mode_r != MODE_REL && mode_r != MODE_BIAS;
                if (mode_r == MODE_IND_P0) mem_addr_out = zext_y;
                if (mode_r == MODE_IND_REL) mem_addr_out = rel_sum;
            end
            // first pass of a mode 7 jump reads at the resolved word,
            // otherwise the low byte of the indirect word follows
            S_IW_HI: begin
                mem_rd_out   = mode_r != MODE_EXT;
                mem_addr_out = ind_pass ? ext_addr : oar + 15'h0001;
            end
            default: mem_rd_out = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // datapath registers; each step takes the byte read last cycle
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state    <= S_IDLE;
            opcode   <= 8'h00;
            byte2    <= 8'h00;
            byte_hi  <= 8'h00;
            pc       <= 15'h0000;
            oar      <= 15'h0000;
            wlen     <= WLEN_RESET;
            ovf      <= OVF_RESET;
            taken    <= 1'b0;
            ind_pass <= 1'b0;
            ctrl     <= '0;
        end else begin
            state <= next_state;
            if (ovf_set_in) ovf <= 1'b1;
            case (state)
                S_IDLE: if (start_in) begin
                    pc    <= pc_in;
                    taken <= 1'b0;
                    ctrl  <= '0;
                end
                S_OPC: pc <= pc + 15'h0001;
                S_B2: begin
                    opcode <= mem_data_in;
                    if (mem_rd_out) pc <= pc + 15'h0001;
                    // only codes 08..0f touch length; overflow also clears on the jumps 10 and 18
                    if (mem_data_in[7:3] == 5'h01) begin
                        wlen <= mem_data_in[1:0];
                        ovf  <= mem_data_in[2] | ovf_set_in;
                    end
                    if (mem_data_in[7:3] == 5'h00) ctrl <= ctrl_t'(
                        {8'h80 >> mem_data_in[2:0], 1'b0});
                    if (mem_data_in == CODE_IDLE) ctrl.idle_op <= 1'b1;
                    if (memref_b2 && mode == MODE_INDEX)
                        oar <= regs_in.index_x[14:0];
                    // literal address is the byte after the opcode
                    if (memref_b2 && mode == MODE_LIT && !jump_b2)
                        oar <= pc;
                    ind_pass <= jump_b2 && mode == MODE_LIT;
                end
                S_B3: begin
                    byte2 <= mem_data_in;
                    // only instruction bytes advance the counter
                    if (!cjump && (mode_r == MODE_EXT || mode_r == MODE_LIT))
                        pc <= pc + 15'h0001;
                    if (cjump) begin
                        taken <= take;
                        if (opcode[2:0] == 3'h0 && ovf && !ovf_set_in)
                            ovf <= 1'b0;
                        if (take) oar <= rel_sum;
                        else oar <= pc;
                    end else case (mode_r)
                        MODE_PAGE0:   oar <= zext_y;
                        MODE_REL:     oar <= rel_sum;
                        MODE_BIAS:    oar <= bias_sum;
                        // pointer kept so the low byte can follow
                        MODE_IND_P0:  oar <= zext_y;
                        MODE_IND_REL: oar <= rel_sum;
                        default:      oar <= oar;
                    endcase
                end
                S_IW_HI: begin
                    if (ind_pass) begin
                        oar      <= ext_addr;
                        ind_pass <= 1'b0;
                    end else if (mode_r == MODE_EXT)
                        oar <= ext_addr;
                    else
                        byte_hi <= mem_data_in;
                end
                S_IW_LO: begin
                    if (mode_r != MODE_EXT)
                        oar <= ind_addr;
                end
                default: oar <= oar;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs, data from flip-flops
    assign oper_addr_out    = oar;
    assign pc_out           = pc;
    assign done_out         = state == S_DONE;
    assign busy_out         = state != S_IDLE;
    assign op_field_out     = op_r;
    assign mode_out         = mode_r;
    assign memref_out       = memref;
    assign var_len_out      = var_len;
    assign oper_bytes_out   = nbytes;
    assign word_len_out     = wlen;
    assign overflow_out     = ovf;
    assign branch_taken_out = taken;
    assign ctrl_out         = ctrl;

    ////////////////////////////////////////////////////////////////////
    // checks
    property p_index4;
        @(posedge clock_in) disable iff (!arst_n_in)
        (state == S_B2 && mem_data_in[7:5] >= 3'h3 &&
         mem_data_in[2:0] == MODE_INDEX)
        |=> oar == $past(regs_in.index_x[14:0]);
    endproperty
    a_index4: assert property (p_index4) else $error("mode 4 wrong");
    property p_page0;
        @(posedge clock_in) disable iff (!arst_n_in)
        (state == S_B3 && memref && mode_r == MODE_PAGE0)
        |=> oar[14:8] == 7'h00;
    endproperty
    a_page0: assert property (p_page0) else $error("page0 high");
    property p_done;
        @(posedge clock_in) disable iff (!arst_n_in)
        (state == S_IDLE && start_in) |-> ##[3:7] done_out;
    endproperty
    a_done: assert property (p_done) else $error("no done");
    property p_wlen;
        @(posedge clock_in) disable iff (!arst_n_in)
        !(state == S_B2 && mem_data_in[7:3] == 5'h01) |=> $stable(wlen);
    endproperty
    a_wlen: assert property (p_wlen) else $error("wlen changed");
    property p_ovf;
        @(posedge clock_in) disable iff (!arst_n_in)
        (state == S_B2 && mem_data_in[7:2] == 6'h03 && !ovf_set_in)
        |=> ovf;
    endproperty
    a_ovf: assert property (p_ovf) else $error("ovf not set");
    property p_litpc;
        @(posedge clock_in) disable iff (!arst_n_in)
        (done_out && memref && mode_r == MODE_LIT && !is_jump)
        |-> oar == pc;
    endproperty
    a_litpc: assert property (p_litpc) else $error("literal addr");
    property p_bias;
        @(posedge clock_in) disable iff (!arst_n_in)
        (state == S_B3 && memref && mode_r == MODE_BIAS)
        |=> oar == $past(regs_in.index_x[14:0]) + {7'h00, $past(mem_data_in)};
    endproperty
    a_bias: assert property (p_bias) else $error("bias addr");
    property p_idle;
        @(posedge clock_in) disable iff (!arst_n_in)
        done_out |=> state == S_IDLE;
    endproperty
    a_idle: assert property (p_idle) else $error("stuck");
    c_jump: cover property (@(posedge clock_in) done_out && is_jump && memref);
    c_cj:   cover property (@(posedge clock_in) done_out && cjump && taken);
    c_ind:  cover property (@(posedge clock_in) done_out && mode_r == MODE_IND_REL);
endmodule
`default_nettype wire

// ---- tb/core_mem_model.sv ----
// Purpose: byte-wide core memory standing behind the operand decoder
// Assumes: one read strobe, data answers one clock after it
// Notes:   bench preloads mem directly; no write port is modelled
`timescale 1ns/1ps
`default_nettype none
module core_mem_model (
    input  wire logic        clock_in,
    input  wire logic        rd_in,
    input  wire logic [14:0] addr_in,
    output logic      [7:0]  data_out
);
    logic [7:0] mem [0:32767];

    ////////////////////////////////////////////////////////////////////////
    // read answer one cycle later; between reads the bus flips every
    // cycle so a stale byte reads inverted after an odd number of idle cycles
    initial data_out = 8'h00;
    always @(posedge clock_in) begin
        if (rd_in) begin
            data_out <= mem[addr_in];
        end else begin
            data_out <= ~data_out;
        end
    end
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Purpose: self-checking bench for the operand address decoder
// Assumes: memory latency of one cycle, stimulus on falling edge
// Notes:   index register held at 16'h7ff0 for the addressing checks
`timescale 1ns/1ps
`default_nettype none
module tb;
    import opaddr_pkg::*;
    logic        clock_in, arst_n_in, start_in, ovf_set_in;
    logic        mem_rd, done, busy, memref, var_len, overflow, taken;
    logic        taken_s;
    logic [14:0] pc_in, mem_addr, oar, pc_o;
    logic [7:0]  mem_data;
    logic [4:0]  op_f;
    logic [2:0]  mode, obytes;
    logic [1:0]  wlen;
    regs_t       regs_in;
    ctrl_t       ctrl, ctrl_s;
    int          mismatches, samples_checked, cycles;
    logic [15:0] jt;

    operand_address_decoder i_operand_address_decoder (
        .clock_in(clock_in), .arst_n_in(arst_n_in), .start_in(start_in),
        .pc_in(pc_in), .regs_in(regs_in), .ovf_set_in(ovf_set_in),
        .mem_data_in(mem_data), .mem_rd_out(mem_rd),
        .mem_addr_out(mem_addr), .oper_addr_out(oar), .pc_out(pc_o),
        .done_out(done), .busy_out(busy), .op_field_out(op_f),
        .mode_out(mode), .memref_out(memref), .var_len_out(var_len),
        .oper_bytes_out(obytes), .word_len_out(wlen),
        .overflow_out(overflow), .branch_taken_out(taken),
        .ctrl_out(ctrl));
    core_mem_model i_core_mem_model (
        .clock_in(clock_in), .rd_in(mem_rd), .addr_in(mem_addr),
        .data_out(mem_data));

    ////////////////////////////////////////////////////////////////////////
    // clock and hang guard; the whole run needs well under 2000 cycles
    initial begin
        clock_in = 1'b0;
        forever #2.5 clock_in = ~clock_in;
    end
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // start stays high a second cycle while busy, which must be ignored;
    // exp below zero skips the address compare
    task automatic decode(input logic [14:0] pc, input logic [7:0] b0,
                          input logic [7:0] b1, input logic [7:0] b2,
                          input int lat, input int exp);
        int n;
        n = 0;
        i_core_mem_model.mem[pc] = b0;
        i_core_mem_model.mem[15'(pc + 15'd1)] = b1;
        i_core_mem_model.mem[15'(pc + 15'd2)] = b2;
        pc_in = pc;
        start_in = 1'b1;
        while (done !== 1'b1 && n < 12) begin
            @(negedge clock_in);
            n++;
            if (n == 2) start_in = 1'b0;
        end
        ctrl_s = ctrl;
        taken_s = taken;
        chk(16'(n), 16'(lat));
        if (exp >= 0) chk(16'(oar), 16'(exp));
        @(negedge clock_in);
        chk(16'(done), 16'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        arst_n_in = 1'b0;
        start_in = 1'b0;
        ovf_set_in = 1'b0;
        pc_in = 15'h0;
        regs_in = '0;
        repeat (6) @(negedge clock_in);
        arst_n_in = 1'b1;
        chk(16'(oar), 16'h0);
        chk(16'({busy, overflow, wlen}), 16'h1);
        // one-byte control codes and the idle code
        for (int c = 0; c < 8; c++) begin
            decode(15'h0100, 8'(c), 8'h00, 8'h00, 3, -1);
            chk(16'(ctrl_s), 16'h100 >> c);
        end
        decode(15'h0100, CODE_IDLE, 8'h00, 8'h00, 3, -1);
        chk(16'(ctrl_s), 16'h001);
        chk(16'({overflow, wlen}), 16'h1);
        for (int c = 8; c < 16; c++) begin
            decode(15'h0100, 8'(c), 8'h00, 8'h00, 3, -1);
            chk(16'({overflow, wlen}), 16'(c & 7));
        end
        // conditional jumps: A zero, B nonzero, X negative, overflow set
        regs_in = {16'h0000, 16'h1234, 16'h8000};
        jt = 16'hdd23;
        for (int k = 0; k < 16; k++) begin
            decode(15'h0200, 8'(8'h10 + k), 8'h05, 8'h00, 4,
                   jt[k] ? 'h0207 : 'h0202);
            chk(16'(taken_s), 16'(jt[k]));
            if (k == 0) chk(16'(overflow), 16'h0);
        end
        @(negedge clock_in);
        ovf_set_in = 1'b1;
        @(negedge clock_in);
        ovf_set_in = 1'b0;
        chk(16'(overflow), 16'h1);
        // addressing modes with indirect words in memory
        regs_in = {16'h0000, 16'h0000, 16'h7ff0};
        i_core_mem_model.mem[15'h0040] = 8'h80;
        i_core_mem_model.mem[15'h0041] = 8'h20;
        i_core_mem_model.mem[15'h0042] = 8'h12;
        i_core_mem_model.mem[15'h0043] = 8'h34;
        i_core_mem_model.mem[15'h1012] = 8'h80;
        i_core_mem_model.mem[15'h1013] = 8'h05;
        i_core_mem_model.mem[15'h0030] = 8'h00;
        i_core_mem_model.mem[15'h0031] = 8'h77;
        i_core_mem_model.mem[15'h0032] = 8'h80;
        i_core_mem_model.mem[15'h0033] = 8'h11;
        decode(15'h1000, 8'he0, 8'ha5, 8'h00, 4, 'h00a5);
        chk(16'(var_len), 16'h0);
        decode(15'h1000, 8'he1, 8'h80, 8'h00, 4, 'h0f82);
        chk(16'({op_f, mode, memref}), 16'h01c3);
        decode(15'h1000, 8'he1, 8'h7f, 8'h00, 4, 'h1081);
        decode(15'h7ffe, 8'he1, 8'h10, 8'h00, 4, 'h0010);
        decode(15'h1000, 8'he2, 8'h40, 8'h00, 6, 'h0010);
        chk(16'(pc_o), 16'h1002);
        decode(15'h1000, 8'he2, 8'h42, 8'h00, 6, 'h1234);
        decode(15'h1000, 8'he3, 8'h10, 8'h00, 6, 'h7ff5);
        decode(15'h1000, 8'he4, 8'h00, 8'h00, 3, 'h7ff0);
        chk(16'(pc_o), 16'h1001);
        decode(15'h1000, 8'he5, 8'hf0, 8'h00, 4, 'h00e0);
        decode(15'h1000, 8'he6, 8'h12, 8'h34, 6, 'h1234);
        chk(16'(pc_o), 16'h1003);
        decode(15'h1000, 8'he6, 8'h81, 8'h00, 6, 'h00f0);
        decode(15'h1000, 8'he7, 8'h00, 8'h00, 3, 'h1001);
        chk(16'(pc_o), 16'h1001);
        // a mode 7 jump takes one step more than mode 6 for its second word
        decode(15'h1000, 8'h67, 8'h80, 8'h40, 7, 'h0077);
        chk(16'(pc_o), 16'h1003);
        decode(15'h1000, 8'h6f, 8'h00, 8'h32, 7, 'h0001);
        chk(16'(wlen), 16'h3);
        // variable length request versus fixed-only type bit
        decode(15'h1000, 8'he8, 8'ha5, 8'h00, 4, 'h00a5);
        chk(16'({var_len, obytes}), 16'hc);
        decode(15'h1000, 8'h98, 8'ha5, 8'h00, 4, 'h00a5);
        chk(16'(var_len), 16'h0);
        stop_test();
    end
endmodule
`default_nettype wire
